// >>> rtl/smsp_top.sv
// synchronous master serial port with axi4-lite register slave
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module smsp_top #(
  parameter int RX_DEPTH = 2                     // receive fifo entries
) (
  input  wire  logic        mclk,                // system clock
  input  wire  logic        rstn,                // async reset, low
  input  wire  logic [7:0]  s_axi_awaddr,        // write address
  input  wire  logic        s_axi_awvalid,       // write address valid
  output var   logic        s_axi_awready,       // write address ready
  input  wire  logic [31:0] s_axi_wdata,         // write data
  input  wire  logic [3:0]  s_axi_wstrb,         // byte enables
  input  wire  logic        s_axi_wvalid,        // write data valid
  output var   logic        s_axi_wready,        // write data ready
  output var   logic [1:0]  s_axi_bresp,         // write response
  output var   logic        s_axi_bvalid,        // write response valid
  input  wire  logic        s_axi_bready,        // write response ready
  input  wire  logic [7:0]  s_axi_araddr,        // read address
  input  wire  logic        s_axi_arvalid,       // read address valid
  output var   logic        s_axi_arready,       // read address ready
  output var   logic [31:0] s_axi_rdata,         // read data
  output var   logic [1:0]  s_axi_rresp,         // read response
  output var   logic        s_axi_rvalid,        // read data valid
  input  wire  logic        s_axi_rready,        // read data ready
  output var   logic        clock_pin_o,         // shift clock out
  output var   logic        clock_pin_oe,        // clock driver on
  input  wire  logic        data_pin_i,          // data line in
  output var   logic        data_pin_o,          // data line out
  output var   logic        data_pin_oe          // data driver on
);
  import smsp_pkg::*;

  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(RX_DEPTH);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge for writable registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // fifo pointer advance with wrap at the depth
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [CW-1:0] n);
    logic [CW+PW-1:0] s;
    s = (CW+PW)'(p) + (CW+PW)'(n);
    if (s >= (CW+PW)'(RX_DEPTH)) begin
      s = s - (CW+PW)'(RX_DEPTH);
    end
    return s[PW-1:0];
  endfunction : ptr_add

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_ff;
  logic [15:0]       div_ff;
  logic [7:0]        hold_ff;
  logic              hold_full_ff;
  logic              dt_meta_ff;
  logic              dt_sync_ff;
  smsp_state_e       state_ff;
  smsp_state_e       nxt_state;
  logic [3:0]        bitcnt_ff;
  logic [8:0]        tsh_ff;
  logic [8:0]        rsh_ff;
  logic              is_rx_ff;
  logic              nine_ff;
  logic [15:0]       tick_cnt_ff;
  logic [8:0]        fifo_ff [RX_DEPTH];
  logic [PW-1:0]     rd_ptr_ff;
  logic [CW-1:0]     cnt_ff;
  logic              ovr_ff;
  logic              ovr_cont_ff;
  logic              aw_have_ff;
  logic              w_have_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;

  // ---------------------------------------------------------------
  // bus handshakes and decode
  // ---------------------------------------------------------------
  logic        aw_hs, w_hs, ar_hs, do_wr;
  logic        nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid;
  logic        wr_ctrl, wr_txd, wr_div, wr_ok, rd_rx;
  logic [31:0] ctrl_merged, div_merged;
  assign aw_hs       = s_axi_awvalid & s_axi_awready;
  assign w_hs        = s_axi_wvalid & s_axi_wready;
  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign do_wr       = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  assign nxt_aw_have = do_wr ? 1'b0 : (aw_have_ff | aw_hs);
  assign nxt_w_have  = do_wr ? 1'b0 : (w_have_ff | w_hs);
  assign nxt_bvalid  = do_wr | (s_axi_bvalid & ~s_axi_bready);
  assign nxt_rvalid  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign wr_ctrl     = do_wr & (awaddr_ff == ADDR_CTRL);
  assign wr_txd      = do_wr & (awaddr_ff == ADDR_TXD) & wstrb_ff[0];
  assign wr_div      = do_wr & (awaddr_ff == ADDR_DIV);
  assign wr_ok       = (awaddr_ff == ADDR_CTRL) | (awaddr_ff == ADDR_STAT) | (awaddr_ff == ADDR_TXD)
                     | (awaddr_ff == ADDR_RXD) | (awaddr_ff == ADDR_DIV);
  assign rd_rx       = ar_hs & (s_axi_araddr == ADDR_RXD);
  assign ctrl_merged = lane_merge(32'(ctrl_ff), wdata_ff, wstrb_ff);
  assign div_merged  = lane_merge(32'(div_ff), wdata_ff, wstrb_ff);

  // ---------------------------------------------------------------
  // port mode and engine control terms
  // ---------------------------------------------------------------
  logic        port_on, port_act, rx_dir, tick, start_tx, start_rx, abort, done, rx_done;
  logic        push, pop, ovr_set, ovr_clr;
  logic [15:0] div_eff;
  logic [8:0]  rx_word;
  logic [PW-1:0] wr_idx;
  assign port_on  = ctrl_ff[CB_PORT];
  assign port_act = port_on & ctrl_ff[CB_SYNC] & ctrl_ff[CB_CMST];
  assign rx_dir   = ctrl_ff[CB_SNGL] | ctrl_ff[CB_CONT];
  assign div_eff  = ctrl_ff[CB_WIDE] ? div_ff : {8'h00, div_ff[7:0]};
  assign tick     = (tick_cnt_ff == div_eff);
  assign start_tx = port_act & ~rx_dir & ctrl_ff[CB_TXON] & hold_full_ff;
  assign start_rx = port_act & rx_dir & ~ovr_ff;
  // dropping continuous receive with single off kills the character
  assign abort    = (state_ff != ST_IDLE)
                  & (~port_act | (is_rx_ff & ~ctrl_ff[CB_SNGL] & ~ctrl_ff[CB_CONT]));
  assign done     = (state_ff == ST_TRAIL) & tick & (bitcnt_ff == 4'h1) & ~abort;
  assign rx_done  = done & is_rx_ff;
  assign rx_word  = nine_ff ? rsh_ff : {1'b0, rsh_ff[8:1]};
  assign push     = rx_done & ~ovr_ff & (cnt_ff != FULL_CNT);
  assign ovr_set  = rx_done & ~ovr_ff & (cnt_ff == FULL_CNT);
  assign pop      = rd_rx & (cnt_ff != '0);
  assign ovr_clr  = ovr_ff & (ovr_cont_ff ? ~ctrl_ff[CB_CONT] : rd_rx);
  assign wr_idx   = ptr_add(rd_ptr_ff, cnt_ff);

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  // ready comes from a flop so one address and one data at a time
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_have_ff    <= nxt_aw_have;
      w_have_ff     <= nxt_w_have;
      s_axi_awready <= ~nxt_aw_have & ~nxt_bvalid;
      s_axi_wready  <= ~nxt_w_have & ~nxt_bvalid;
      s_axi_bvalid  <= nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_mux = 32'(ctrl_ff);
      ADDR_STAT: rd_mux = {27'h0, state_ff == ST_IDLE, ~hold_full_ff, fifo_ff[rd_ptr_ff][8],
                           cnt_ff != '0, ovr_ff};
      ADDR_TXD:  rd_mux = {24'h0, hold_ff};
      ADDR_RXD:  rd_mux = {24'h0, fifo_ff[rd_ptr_ff][7:0]};
      ADDR_DIV:  rd_mux = {16'h0, div_ff};
      default:   rd_ok  = 1'b0;
    endcase
  end

  // read answer is taken at the address handshake
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~nxt_rvalid;
      s_axi_rvalid  <= nxt_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // software write beats the hardware clear of single receive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= ctrl_merged[CTRL_W-1:0];
    end else if (rx_done | ~port_on) begin
      ctrl_ff[CB_SNGL] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= DIV_RST;
    end else if (wr_div) begin
      div_ff <= div_merged[15:0];
    end
  end

  // holding register: a fresh write survives a same-cycle transfer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_ff      <= 8'h00;
      hold_full_ff <= 1'b0;
    end else begin
      if (wr_txd) begin
        hold_ff <= wdata_ff[7:0];
      end
      hold_full_ff <= port_on & (wr_txd | (hold_full_ff & ~(start_tx & (state_ff == ST_IDLE))));
    end
  end

  // ---------------------------------------------------------------
  // data pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dt_meta_ff <= 1'b0;
      dt_sync_ff <= 1'b0;
    end else begin
      dt_meta_ff <= data_pin_i;
      dt_sync_ff <= dt_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  // each bit is a lead half then a trail half of div+1 cycles
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:  if (start_tx | start_rx) nxt_state = ST_LEAD;
      ST_LEAD:  if (tick) nxt_state = ST_TRAIL;
      ST_TRAIL: if (tick) nxt_state = (bitcnt_ff == 4'h1) ? ST_IDLE : ST_LEAD;
      default:  nxt_state = ST_IDLE;
    endcase
    if (abort) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff  <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      tsh_ff    <= 9'h000;
      rsh_ff    <= 9'h000;
      is_rx_ff  <= 1'b0;
      nine_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (!abort) begin
        unique case (state_ff)
          ST_IDLE: begin
            if (start_tx) begin
              tsh_ff    <= {ctrl_ff[CB_TBIT], hold_ff};
              bitcnt_ff <= ctrl_ff[CB_TNIN] ? BITS9 : BITS8;
              nine_ff   <= ctrl_ff[CB_TNIN];
              is_rx_ff  <= 1'b0;
            end else if (start_rx) begin
              bitcnt_ff <= ctrl_ff[CB_RNIN] ? BITS9 : BITS8;
              nine_ff   <= ctrl_ff[CB_RNIN];
              is_rx_ff  <= 1'b1;
            end
          end
          ST_LEAD: begin
            if (tick & is_rx_ff) begin
              rsh_ff <= {dt_sync_ff, rsh_ff[8:1]};
            end
          end
          ST_TRAIL: begin
            if (tick & (bitcnt_ff != 4'h1)) begin
              bitcnt_ff <= bitcnt_ff - 4'h1;
              tsh_ff    <= {1'b0, tsh_ff[8:1]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // half-period counter restarts at each phase boundary
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= 16'h0000;
    end else if ((state_ff == ST_IDLE) | tick | abort) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // receive fifo and overrun
  // ---------------------------------------------------------------
  // overrun set wins over its clear; clearing enable empties all
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      ovr_ff      <= 1'b0;
      ovr_cont_ff <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++) begin
        fifo_ff[i] <= 9'h000;
      end
    end else if (!port_on) begin
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      ovr_ff    <= 1'b0;
    end else begin
      if (push) begin
        fifo_ff[wr_idx] <= rx_word;
      end
      if (pop) begin
        rd_ptr_ff <= ptr_add(rd_ptr_ff, CW'(1));
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
      if (ovr_set) begin
        ovr_ff      <= 1'b1;
        ovr_cont_ff <= ctrl_ff[CB_CONT];
      end else if (ovr_clr) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // clock sits at idle level except in lead halves
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clock_pin_o  <= 1'b0;
      clock_pin_oe <= 1'b0;
      data_pin_o   <= 1'b0;
      data_pin_oe  <= 1'b0;
    end else begin
      clock_pin_o  <= (nxt_state == ST_LEAD) ? ~ctrl_ff[CB_CPOL] : ctrl_ff[CB_CPOL];
      clock_pin_oe <= port_act;
      data_pin_oe  <= port_act & ~rx_dir;
      if ((state_ff == ST_IDLE) & start_tx & ~abort) begin
        data_pin_o <= hold_ff[0];
      end else if ((state_ff == ST_TRAIL) & tick & (bitcnt_ff != 4'h1) & ~is_rx_ff) begin
        data_pin_o <= tsh_ff[1];
      end
    end
  end
endmodule : smsp_top
`default_nettype wire

// >>> rtl/smsp_pkg.sv
// constants and types of the synchronous master serial port
// Functional notes
// - no start or stop bits, data only
// - master when sync, clock master, enable set
// - both receive enables clear means transmit
// - master drives clock pin in both directions
// - one clock per data bit, no extras
// - polarity picks idle level and change edge
// - data changes on leading edge, holds
// - transmit drives data and clock pins
// - holding write starts, waits for shifter
// - nine-bit transmit takes ninth bit field
// - receive releases data pin, keeps clock
// - single receive clocks one character, clears
// - continuous runs; clearing aborts partial character
// - both set: single clears, continuous continues
// - sample data pin on trailing edge
// - two-entry fifo, flag while entries remain
// - third character sets overrun, keeps stored
// - overrun clear by read or continuous clear
// - nine-bit receive, ninth bit of oldest
package smsp_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TXD  = 8'h08;
  localparam logic [7:0] ADDR_RXD  = 8'h0c;
  localparam logic [7:0] ADDR_DIV  = 8'h10;
  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_W   = 11;
  localparam int CB_PORT  = 0;
  localparam int CB_SYNC  = 1;
  localparam int CB_CMST  = 2;
  localparam int CB_SNGL  = 3;
  localparam int CB_CONT  = 4;
  localparam int CB_TXON  = 5;
  localparam int CB_TNIN  = 6;
  localparam int CB_TBIT  = 7;
  localparam int CB_RNIN  = 8;
  localparam int CB_CPOL  = 9;
  localparam int CB_WIDE  = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [15:0]       DIV_RST  = 16'h0000;
  // ---------------------------------------------------------------
  // character sizes and bus answers
  // ---------------------------------------------------------------
  localparam logic [3:0] BITS8     = 4'h8;
  localparam logic [3:0] BITS9     = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SERR = 2'h2;
  // shift engine phases, gray along idle, lead, trail
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b11
  } smsp_state_e;
endpackage : smsp_pkg

// >>> verif/smsp_props.sv
// concurrent checks on the pins and register bus of the serial port
`timescale 1ns/1ps
`default_nettype none
module smsp_props (
  input wire logic        mclk,          // clock
  input wire logic        rstn,          // reset, low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        clock_pin_o,   // shift clock
  input wire logic        clock_pin_oe,  // clock driver on
  input wire logic        data_pin_o,    // data out
  input wire logic        data_pin_oe    // data driver on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  // tb offers address and data together, so both land at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not one cycle after capture");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed early");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while one pending");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while one pending");
  // ---------------------------------------------------------------
  // link pins
  // ---------------------------------------------------------------
  a_tx_drives_clk: assert property (data_pin_oe |-> clock_pin_oe)
    else $error("data driven without clock driver");
  a_data_on_lead: assert property (data_pin_oe && $past(data_pin_oe) && $changed(data_pin_o) |-> $changed(clock_pin_o))
    else $error("data changed away from a leading edge");
endmodule : smsp_props
bind smsp_top smsp_props u_props (.mclk(mclk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe),
  .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));
`default_nettype wire

// >>> verif/smsp_slave_model.sv
// behavioural slave on the far side of the shift clock and data line
`timescale 1ns/1ps
`default_nettype none
module smsp_slave_model (
  input wire logic        sck,     // shift clock
  input wire logic        sck_oe,  // clock driven
  input wire logic        pol,     // idle level
  input wire logic        m_o,     // master data
  input wire logic        m_oe,    // master drives
  input wire logic        clr,     // restart counts
  input wire logic [3:0]  nbits,   // bits per char
  input wire logic [8:0]  tx_word, // char we send
  output var logic        line,    // resolved data wire
  output var logic [15:0] cap,     // bits seen
  output int              edges    // trailing edges
);
  logic sl_d;
  int   tidx;
  initial sl_d = 1'b0;
  // wire level: master wins while it drives
  always_comb line = m_oe ? m_o : sl_d;
  // leading edge presents a bit, trailing edge takes one; no framing bits
  always @(sck or posedge clr) begin
    if (clr) begin
      edges = 0;
      tidx = 0;
      cap = '0;
    end else if (sck_oe && sck != pol) begin
      sl_d = tx_word[tidx];
      tidx = (tidx + 1) % int'(nbits);
    end else if (sck_oe) begin
      if (edges < 16) cap[edges] = line;
      edges++;
      // hold runs out: line must not keep the old bit
      sl_d <= #120 ~sl_d;
    end
  end
endmodule : smsp_slave_model
`default_nettype wire

// >>> verif/tb_top.sv
// register-level testbench of the synchronous master serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import smsp_pkg::*;
  localparam logic [31:0] MST = (32'h1 << CB_PORT) | (32'h1 << CB_SYNC) | (32'h1 << CB_CMST);
  logic        mclk, rstn, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic        ck, ck_oe, dq_i, dq_o, dq_oe, clr, pol;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  logic [3:0]  nb;
  logic [8:0]  txw;
  logic [15:0] cap;
  int          edges, bad_count, num_checks;
  smsp_top DUT (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .clock_pin_o(ck),
    .clock_pin_oe(ck_oe), .data_pin_i(dq_i), .data_pin_o(dq_o), .data_pin_oe(dq_oe));
  smsp_slave_model u_slave (.sck(ck), .sck_oe(ck_oe), .pol(pol), .m_o(dq_o), .m_oe(dq_oe), .clr(clr),
    .nbits(nb), .tx_word(txw), .line(dq_i), .cap(cap), .edges(edges));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] fb(input int p);
    return 32'h1 << p;
  endfunction : fb
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // address and data offered together, each dropped when taken
  task reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (!awr);
        awv <= 1'b0;
      end
      begin
        do @(posedge mclk); while (!wr_r);
        wv <= 1'b0;
      end
    join
    do @(posedge mclk); while (!bv);
    br <= 1'b0;
    check(32'(bresp), 32'(er));
    @(posedge mclk); // pins launched by the write settle first
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge mclk); while (!arr);
    arv <= 1'b0;
    do @(posedge mclk); while (!rv);
    d = rdat;
    rr <= 1'b0;
    check(32'(rresp), 32'(er));
  endtask : reg_rd
  // bounded poll of the status word
  task wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      reg_rd(ADDR_STAT, s, RESP_OKAY);
      n++;
    end while ((s & m) != v && n < 2000);
    check(s & m, v);
  endtask : wait_stat
  task restart_slave(input logic [3:0] bits, input logic [8:0] w);
    nb <= bits;
    txw <= w;
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask : restart_slave
  // hang guard, well beyond the few thousand cycles the run needs
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    results;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    int          n, e;
    {rstn, awv, wv, br, arv, rr, pol} = '0;
    {awa, ara, wd, txw} = '0;
    clr = 1'b1;
    nb = BITS8;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    // reset values and an unmapped place
    reg_rd(ADDR_CTRL, d, RESP_OKAY);
    check(d, 32'(CTRL_RST));
    reg_rd(ADDR_DIV, d, RESP_OKAY);
    check(d, 32'(DIV_RST));
    reg_rd(ADDR_STAT, d, RESP_OKAY);
    check(d, 32'h18);
    reg_wr(8'h40, 32'h1, RESP_SERR);
    reg_rd(8'h40, d, RESP_SERR);
    check(d, 32'h0);
    // two characters back to back, second waits; high divisor byte unused
    restart_slave(BITS8, 9'h0);
    reg_wr(ADDR_DIV, 32'h103, RESP_OKAY);
    reg_wr(ADDR_CTRL, MST | fb(CB_TXON), RESP_OKAY);
    check(32'(ck_oe), 32'h1);
    check(32'(dq_oe), 32'h1);
    reg_wr(ADDR_TXD, 32'ha5, RESP_OKAY);
    reg_wr(ADDR_TXD, 32'h3c, RESP_OKAY);
    wait_stat(32'h18, 32'h18);
    check(32'(edges), 32'd16);
    check(32'(cap), 32'h3ca5);
    check(32'(ck), 32'h0);
    // nine bits, clock idling high, wide divider makes bits slow
    reg_wr(ADDR_CTRL, fb(CB_CPOL), RESP_OKAY);
    pol <= 1'b1;
    restart_slave(BITS8, 9'h0);
    reg_wr(ADDR_CTRL, MST | fb(CB_TXON) | fb(CB_TNIN) | fb(CB_TBIT) | fb(CB_CPOL) | fb(CB_WIDE), RESP_OKAY);
    check(32'(ck), 32'h1);
    reg_wr(ADDR_TXD, 32'h5a, RESP_OKAY);
    repeat (200) @(posedge mclk);
    check(32'(edges), 32'd0);
    wait_stat(32'h18, 32'h18);
    check(32'(edges), 32'd9);
    check(32'(cap), 32'h15a);
    // single receive
    reg_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    pol <= 1'b0;
    restart_slave(BITS8, 9'h0c3);
    reg_wr(ADDR_CTRL, MST, RESP_OKAY);
    reg_wr(ADDR_CTRL, MST | fb(CB_SNGL), RESP_OKAY);
    check(32'(dq_oe), 32'h0);
    check(32'(ck_oe), 32'h1);
    wait_stat(32'h2, 32'h2);
    reg_rd(ADDR_CTRL, d, RESP_OKAY);
    check(d, MST);
    check(32'(edges), 32'd8);
    reg_rd(ADDR_RXD, d, RESP_OKAY);
    check(d, 32'hc3);
    wait_stat(32'h2, 32'h0);
    // both enables, nine bits, left to overrun
    restart_slave(BITS9, 9'h1a5);
    reg_wr(ADDR_CTRL, MST | fb(CB_RNIN) | fb(CB_SNGL) | fb(CB_CONT), RESP_OKAY);
    wait_stat(32'h1, 32'h1);
    reg_rd(ADDR_CTRL, d, RESP_OKAY);
    check(d, MST | fb(CB_RNIN) | fb(CB_CONT));
    reg_rd(ADDR_STAT, d, RESP_OKAY);
    check(d & 32'h7, 32'h7);
    reg_rd(ADDR_RXD, d, RESP_OKAY);
    check(d, 32'ha5);
    reg_rd(ADDR_STAT, d, RESP_OKAY);
    check(d & 32'h3, 32'h3);
    reg_rd(ADDR_RXD, d, RESP_OKAY);
    check(d, 32'ha5);
    wait_stat(32'h3, 32'h1);
    reg_wr(ADDR_CTRL, MST | fb(CB_RNIN), RESP_OKAY);
    wait_stat(32'h3, 32'h0);
    // continuous receive stopped inside a character
    restart_slave(BITS8, 9'h0ff);
    reg_wr(ADDR_CTRL, MST | fb(CB_CONT), RESP_OKAY);
    n = 0;
    while (edges < 3 && n < 500) begin
      @(posedge mclk);
      n++;
    end
    check(32'(n < 500), 32'h1);
    reg_wr(ADDR_CTRL, MST, RESP_OKAY);
    e = edges;
    repeat (40) @(posedge mclk);
    check(32'(edges), 32'(e));
    check(32'(ck), 32'h0);
    wait_stat(32'h2, 32'h0);
    results;
  end
endmodule : tb_top
`default_nettype wire
